// File: bit_exec_cfg.svh
// Register offsets, field positions, reset values and opcode constants
`ifndef BIT_EXEC_CFG_SVH
`define BIT_EXEC_CFG_SVH

`define OFF_INSTR 5'h00
`define OFF_PSW 5'h04
`define OFF_ACC 5'h08
`define OFF_PC 5'h0c
`define OFF_MADDR 5'h10
`define OFF_MDATA 5'h14
`define OFF_STAT 5'h18

`define PSW_N 3'h7
`define PSW_V 3'h6
`define PSW_G 3'h5
`define PSW_Z 3'h1
`define PSW_C 3'h0
`define STAT_BUSY 3'h0
`define STAT_ILLEGAL 3'h1
`define RST_PSW 8'h00
`define RST_ACC 8'h00
`define RST_PC 16'h0000

`define OPC_CARRY_AND 8'h8b
`define OPC_CARRY_OR 8'h6b
`define OPC_CARRY_XOR 8'hab
`define OPC_CARRY_LOAD 8'hcb
`define OPC_MEMBIT_INVERT 8'h4b
`define OPC_CARRY_STORE 8'heb
`define OPC_BIT_TEST_DP 8'h0c
`define OPC_BIT_TEST_ABS 8'h1c
`define OPC_TEST_SET 8'h3c
`define OPC_TEST_CLEAR 8'h5c
`define OPC_ACC_FORCE_ONE 8'h0b
`define OPC_ACC_CLEAR 8'h2b
`define OPC_CARRY_CLEAR 8'h20
`define OPC_CARRY_FORCE_ONE 8'ha0
`define OPC_GFLAG_CLEAR 8'h40
`define OPC_GFLAG_FORCE_ONE 8'hc0
`define OPC_OVERFLOW_CLEAR 8'h80
`define OPC_BR_CARRY_ZERO 8'h50
`define OPC_BR_CARRY_ONE 8'hd0
`define OPC_BR_ZERO_ONE 8'hf0
`define OPC_BR_ZERO_ZERO 8'h70
`define OPC_BR_NEGATIVE 8'h90
`define OPC_BR_NONNEGATIVE 8'h10
`define PAT_DP_FORCE_ONE 5'h01
`define PAT_DP_CLEAR 5'h11
`define PAT_BB_ACC 4'h2
`define PAT_BB_DP 4'h3

`define CYC_CARRY_AND 4'h4
`define CYC_CARRY_LOAD 4'h4
`define CYC_CARRY_OR 4'h5
`define CYC_CARRY_XOR 4'h5
`define CYC_INVERT 4'h5
`define CYC_CARRY_STORE 4'h6
`define CYC_BIT_DP 4'h4
`define CYC_BIT_ABS 4'h5
`define CYC_DP_BIT 4'h4
`define CYC_ACC_BIT 4'h2
`define CYC_FLAG_OP 4'h2
`define CYC_TEST_MOD 4'h6
`define CYC_BB_ACC 4'h4
`define CYC_BB_DP 4'h5
`define CYC_COND_BR 4'h2
`define CYC_TAKEN_ADD 4'h2
`define LEN_ONE 16'h0001
`define LEN_TWO 16'h0002
`define LEN_THREE 16'h0003

`endif

// File: bit_exec_pkg.sv
// Types shared by the bit-operation and branch execution unit
package bit_exec_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_RUN} exec_state_t;
   typedef enum logic [4:0] {
      OC_NONE, OC_CAND, OC_COR, OC_CXOR, OC_CLOAD, OC_INVERT, OC_CSTORE,
      OC_BIT_DP, OC_BIT_ABS, OC_DP_SET, OC_DP_CLR, OC_ACC_SET, OC_ACC_CLR,
      OC_FLAG, OC_TSET, OC_TCLR, OC_BB_A, OC_BB_DP, OC_COND_BR
   } op_class_t;
endpackage

// File: bit_exec_timer.sv
// Instruction cycle timer with taken-branch extension
module bit_exec_timer #(
   parameter int W = 4
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic extend,
   output logic [W-1:0] cnt,
   output logic done
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   if (W < 4) begin : g_bad_w
      $error("W too narrow for the longest instruction");
   end

   // Extension adds two cycles less the one now ending
   assign nxt_cnt = load ? load_val :
                    extend ? W'(cnt_ff + W'(1)) :
                    (cnt_ff != '0) ? W'(cnt_ff - W'(1)) : cnt_ff;
   assign done = (cnt_ff == W'(1)) && !extend && !load;
   assign cnt = cnt_ff;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// File: bit_ops_and_branch_exec.sv
// Bit-manipulation and relative-branch execution unit with Avalon slave
`include "bit_exec_cfg.svh"

module bit_ops_and_branch_exec import bit_exec_pkg::*; #(
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic exec_busy
);
   if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_aw
      $error("ADDR_W must lie between 8 and 16");
   end

   function automatic op_class_t op_decode(input logic [7:0] o);
      op_class_t c;
      c = OC_NONE;
      if (o[4:0] == `PAT_DP_FORCE_ONE) c = OC_DP_SET;
      else if (o[4:0] == `PAT_DP_CLEAR) c = OC_DP_CLR;
      else if (o[3:0] == `PAT_BB_ACC) c = OC_BB_A;
      else if (o[3:0] == `PAT_BB_DP) c = OC_BB_DP;
      else begin
         unique case (o)
            `OPC_CARRY_AND: c = OC_CAND;
            `OPC_CARRY_OR: c = OC_COR;
            `OPC_CARRY_XOR: c = OC_CXOR;
            `OPC_CARRY_LOAD: c = OC_CLOAD;
            `OPC_MEMBIT_INVERT: c = OC_INVERT;
            `OPC_CARRY_STORE: c = OC_CSTORE;
            `OPC_BIT_TEST_DP: c = OC_BIT_DP;
            `OPC_BIT_TEST_ABS: c = OC_BIT_ABS;
            `OPC_TEST_SET: c = OC_TSET;
            `OPC_TEST_CLEAR: c = OC_TCLR;
            `OPC_ACC_FORCE_ONE: c = OC_ACC_SET;
            `OPC_ACC_CLEAR: c = OC_ACC_CLR;
            `OPC_CARRY_CLEAR, `OPC_CARRY_FORCE_ONE, `OPC_GFLAG_CLEAR,
            `OPC_GFLAG_FORCE_ONE, `OPC_OVERFLOW_CLEAR: c = OC_FLAG;
            `OPC_BR_CARRY_ZERO, `OPC_BR_CARRY_ONE, `OPC_BR_ZERO_ONE,
            `OPC_BR_ZERO_ZERO, `OPC_BR_NEGATIVE,
            `OPC_BR_NONNEGATIVE: c = OC_COND_BR;
            default: c = OC_NONE;
         endcase
      end
      return c;
   endfunction

   function automatic logic [3:0] base_cycles(input op_class_t c);
      logic [3:0] n;
      n = `CYC_FLAG_OP;
      unique case (c)
         OC_CAND: n = `CYC_CARRY_AND;
         OC_CLOAD: n = `CYC_CARRY_LOAD;
         OC_COR: n = `CYC_CARRY_OR;
         OC_CXOR: n = `CYC_CARRY_XOR;
         OC_INVERT: n = `CYC_INVERT;
         OC_CSTORE: n = `CYC_CARRY_STORE;
         OC_BIT_DP: n = `CYC_BIT_DP;
         OC_BIT_ABS: n = `CYC_BIT_ABS;
         OC_DP_SET, OC_DP_CLR: n = `CYC_DP_BIT;
         OC_ACC_SET, OC_ACC_CLR: n = `CYC_ACC_BIT;
         OC_TSET, OC_TCLR: n = `CYC_TEST_MOD;
         OC_BB_A: n = `CYC_BB_ACC;
         OC_BB_DP: n = `CYC_BB_DP;
         OC_COND_BR: n = `CYC_COND_BR;
         OC_FLAG, OC_NONE: n = `CYC_FLAG_OP;
      endcase
      return n;
   endfunction

   function automatic logic [15:0] instr_len(input op_class_t c);
      logic [15:0] n;
      n = `LEN_THREE;
      if (c == OC_FLAG) n = `LEN_ONE;
      else if (c inside {OC_BIT_DP, OC_DP_SET, OC_DP_CLR, OC_ACC_SET,
                         OC_ACC_CLR, OC_BB_A, OC_COND_BR}) n = `LEN_TWO;
      return n;
   endfunction

   function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic en);
      return en ? new_v : old_v;
   endfunction

   logic [7:0] mem [2**ADDR_W];
   exec_state_t state_ff;
   logic [7:0] opc_ff, op1_ff, op2_ff, acc_ff, psw_ff, mem_rd_ff;
   logic [15:0] pc_ff;
   logic [ADDR_W-1:0] maddr_ff;
   logic ack_ff, illegal_ff, first_ff;
   logic [31:0] rdata_ff;
   logic [3:0] run_cnt_ff, last_cyc_ff;

   logic req, stall, wr_fire, rd_take, start, commit, tdone;
   op_class_t cls;
   logic is_mbit, is_acc, is_abs, inv_op, tbit, mbv, carry, taken;
   logic cond_br;
   logic [2:0] bit_n;
   logic [7:0] mask, opnd, diff, rel, nxt_mem, nxt_acc, nxt_psw;
   logic [15:0] ea16, seq_pc, target;
   logic [ADDR_W-1:0] ea;
   logic [31:0] rd_mux;

   // Bus slave: one wait cycle per read, and per write while idle; data from a register
   assign req = avs_read | avs_write;
   // Writes wait while an instruction owns the state
   assign stall = avs_write & exec_busy;
   assign avs_waitrequest = req & ~ack_ff;
   assign wr_fire = avs_write & ack_ff;
   assign rd_take = req & ~ack_ff & ~stall;
   assign avs_readdata = rdata_ff;
   assign exec_busy = (state_ff != ST_IDLE);
   assign start = wr_fire && avs_address == `OFF_INSTR && avs_byteenable[0];

   // Operand decode
   assign cls = op_decode(opc_ff);
   assign is_mbit = cls inside {OC_CAND, OC_COR, OC_CXOR, OC_CLOAD,
                                OC_INVERT, OC_CSTORE};
   assign is_acc = cls inside {OC_ACC_SET, OC_ACC_CLR, OC_BB_A};
   assign is_abs = cls inside {OC_BIT_ABS, OC_TSET, OC_TCLR};
   assign inv_op = op2_ff[4] & (cls inside {OC_CAND, OC_COR, OC_CXOR,
                                            OC_CLOAD});
   assign bit_n = is_mbit ? op2_ff[7:5] :
                  (is_acc && cls != OC_BB_A) ? op1_ff[2:0] : opc_ff[7:5];
   assign ea16 = is_mbit ? {4'h0, op2_ff[3:0], op1_ff} :
                 is_abs ? {op2_ff, op1_ff} : {8'h00, op1_ff};
   // Upper address bits beyond the array are ignored
   assign ea = ea16[ADDR_W-1:0];
   assign mask = 8'h01 << bit_n;
   assign opnd = is_acc ? acc_ff : mem_rd_ff;
   assign tbit = opnd[bit_n];
   assign mbv = tbit ^ inv_op;
   assign carry = psw_ff[`PSW_C];
   assign diff = acc_ff - mem_rd_ff;
   assign rel = (cls == OC_BB_DP) ? op2_ff : op1_ff;
   assign seq_pc = pc_ff + instr_len(cls);
   assign target = seq_pc + {{8{rel[7]}}, rel};

   always_comb begin
      cond_br = 1'b0;
      unique case (opc_ff)
         `OPC_BR_CARRY_ZERO: cond_br = ~carry;
         `OPC_BR_CARRY_ONE: cond_br = carry;
         `OPC_BR_ZERO_ONE: cond_br = psw_ff[`PSW_Z];
         `OPC_BR_ZERO_ZERO: cond_br = ~psw_ff[`PSW_Z];
         `OPC_BR_NEGATIVE: cond_br = psw_ff[`PSW_N];
         `OPC_BR_NONNEGATIVE: cond_br = ~psw_ff[`PSW_N];
         default: cond_br = 1'b0;
      endcase
   end
   // Set forms have opcode bit 4 low, clear forms high
   assign taken = (cls inside {OC_BB_A, OC_BB_DP}) ?
                  (tbit ^ opc_ff[4]) :
                  (cls == OC_COND_BR) & cond_br;

   always_comb begin
      nxt_mem = mem_rd_ff;
      nxt_acc = acc_ff;
      nxt_psw = psw_ff;
      unique case (cls)
         OC_CAND: nxt_psw[`PSW_C] = carry & mbv;
         OC_COR: nxt_psw[`PSW_C] = carry | mbv;
         OC_CXOR: nxt_psw[`PSW_C] = carry ^ mbv;
         OC_CLOAD: nxt_psw[`PSW_C] = mbv;
         OC_INVERT: nxt_mem = mem_rd_ff ^ mask;
         OC_CSTORE: nxt_mem = carry ? (mem_rd_ff | mask) :
                              (mem_rd_ff & ~mask);
         OC_BIT_DP, OC_BIT_ABS: begin
            nxt_psw[`PSW_Z] = ~|(acc_ff & mem_rd_ff);
            nxt_psw[`PSW_N] = mem_rd_ff[7];
            nxt_psw[`PSW_V] = mem_rd_ff[6];
         end
         OC_DP_SET: nxt_mem = mem_rd_ff | mask;
         OC_DP_CLR: nxt_mem = mem_rd_ff & ~mask;
         OC_ACC_SET: nxt_acc = acc_ff | mask;
         OC_ACC_CLR: nxt_acc = acc_ff & ~mask;
         OC_TSET, OC_TCLR: begin
            nxt_psw[`PSW_N] = diff[7];
            nxt_psw[`PSW_Z] = (diff == 8'h00);
            nxt_mem = (cls == OC_TSET) ? (mem_rd_ff | acc_ff) :
                      (mem_rd_ff & ~acc_ff);
         end
         OC_FLAG: begin
            if (opc_ff == `OPC_CARRY_CLEAR) nxt_psw[`PSW_C] = 1'b0;
            if (opc_ff == `OPC_CARRY_FORCE_ONE) nxt_psw[`PSW_C] = 1'b1;
            if (opc_ff == `OPC_GFLAG_CLEAR) nxt_psw[`PSW_G] = 1'b0;
            if (opc_ff == `OPC_GFLAG_FORCE_ONE) nxt_psw[`PSW_G] = 1'b1;
            if (opc_ff == `OPC_OVERFLOW_CLEAR) nxt_psw[`PSW_V] = 1'b0;
         end
         OC_BB_A, OC_BB_DP, OC_COND_BR, OC_NONE: nxt_psw = psw_ff;
      endcase
   end

   bit_exec_timer #(.W(4)) u_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .load(state_ff == ST_READ),
      .load_val(4'(base_cycles(cls) - 4'h1)),
      .extend(state_ff == ST_RUN && first_ff && taken),
      .cnt(),
      .done(tdone)
   );
   assign commit = (state_ff == ST_RUN) && tdone;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         `OFF_INSTR: rd_mux = {8'h00, op2_ff, op1_ff, opc_ff};
         `OFF_PSW: rd_mux = {24'h0000_00, psw_ff};
         `OFF_ACC: rd_mux = {24'h0000_00, acc_ff};
         `OFF_PC: rd_mux = {16'h0000, pc_ff};
         `OFF_MADDR: rd_mux = 32'(maddr_ff);
         `OFF_MDATA: rd_mux = {24'h0000_00, mem[maddr_ff]};
         `OFF_STAT: rd_mux = {24'h0000_00, last_cyc_ff, 2'b00,
                               illegal_ff, exec_busy};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= rd_take;
         if (rd_take) rdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         first_ff <= 1'b0;
         run_cnt_ff <= 4'h0;
         last_cyc_ff <= 4'h0;
         illegal_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: if (start) state_ff <= ST_READ;
            ST_READ: state_ff <= (cls == OC_NONE) ? ST_IDLE : ST_RUN;
            ST_RUN: if (tdone) state_ff <= ST_IDLE;
         endcase
         first_ff <= (state_ff == ST_READ);
         run_cnt_ff <= start ? 4'h0 :
                       exec_busy ? 4'(run_cnt_ff + 4'h1) : run_cnt_ff;
         if (commit) last_cyc_ff <= 4'(run_cnt_ff + 4'h1);
         // Hardware set wins over a software clear
         if (state_ff == ST_READ && cls == OC_NONE) illegal_ff <= 1'b1;
         else if (wr_fire && avs_address == `OFF_STAT &&
                  avs_byteenable[0] && avs_writedata[`STAT_ILLEGAL])
            illegal_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         opc_ff <= 8'h00;
         op1_ff <= 8'h00;
         op2_ff <= 8'h00;
         acc_ff <= `RST_ACC;
         psw_ff <= `RST_PSW;
         pc_ff <= `RST_PC;
         maddr_ff <= '0;
         mem_rd_ff <= 8'h00;
      end else begin
         if (start) begin
            opc_ff <= avs_writedata[7:0];
            op1_ff <= lane_merge(op1_ff, avs_writedata[15:8],
                                 avs_byteenable[1]);
            op2_ff <= lane_merge(op2_ff, avs_writedata[23:16],
                                 avs_byteenable[2]);
         end
         if (state_ff == ST_READ) mem_rd_ff <= mem[ea];
         if (commit) begin
            acc_ff <= nxt_acc;
            psw_ff <= nxt_psw;
            pc_ff <= taken ? target : seq_pc;
         end else if (wr_fire) begin
            if (avs_address == `OFF_ACC)
               acc_ff <= lane_merge(acc_ff, avs_writedata[7:0],
                                    avs_byteenable[0]);
            if (avs_address == `OFF_PSW)
               psw_ff <= lane_merge(psw_ff, avs_writedata[7:0],
                                    avs_byteenable[0]);
            if (avs_address == `OFF_PC) begin
               pc_ff[7:0] <= lane_merge(pc_ff[7:0], avs_writedata[7:0],
                                        avs_byteenable[0]);
               pc_ff[15:8] <= lane_merge(pc_ff[15:8], avs_writedata[15:8],
                                         avs_byteenable[1]);
            end
            if (avs_address == `OFF_MADDR && &avs_byteenable[1:0])
               maddr_ff <= avs_writedata[ADDR_W-1:0];
         end
      end
   end

   // Data memory has no reset; software initialises it
   always_ff @(posedge sys_clk) begin
      if (commit && !is_acc &&
          cls inside {OC_INVERT, OC_CSTORE, OC_DP_SET, OC_DP_CLR,
                      OC_TSET, OC_TCLR})
         mem[ea] <= nxt_mem;
      else if (wr_fire && avs_address == `OFF_MDATA && avs_byteenable[0])
         mem[maddr_ff] <= avs_writedata[7:0];
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_carry_and_mem: assert property (
      commit && cls == OC_CAND |=>
         psw_ff[`PSW_C] == $past(carry & (tbit ^ op2_ff[4])))
      else $error("carry AND result wrong");
   a_bit_test_flags: assert property (
      commit && cls inside {OC_BIT_DP, OC_BIT_ABS} |=>
         psw_ff[`PSW_Z] == $past(~|(acc_ff & mem_rd_ff)) &&
         psw_ff[`PSW_V] == $past(mem_rd_ff[6]))
      else $error("bit test flags wrong");
   a_dp_clear_mem: assert property (
      commit && cls == OC_DP_CLR |=>
         mem[$past(ea)][$past(bit_n)] == 1'b0 && $stable(psw_ff))
      else $error("dp bit clear failed");
   a_acc_force_one: assert property (
      commit && cls == OC_ACC_SET |=>
         (acc_ff & $past(mask)) == $past(mask) && $stable(psw_ff))
      else $error("acc bit force one failed");
   a_carry_force_one: assert property (
      commit && opc_ff == `OPC_CARRY_FORCE_ONE |=> psw_ff[`PSW_C])
      else $error("carry not forced to one");
   a_xor_timing: assert property (
      state_ff == ST_READ && opc_ff == `OPC_CARRY_XOR |->
         exec_busy [*5] ##1 !exec_busy)
      else $error("carry XOR cycle count wrong");
   a_store_timing: assert property (
      state_ff == ST_READ && opc_ff == `OPC_CARRY_STORE |->
         exec_busy [*6] ##1 !exec_busy)
      else $error("carry store cycle count wrong");
   a_test_set_flags: assert property (
      commit && cls == OC_TSET |=>
         psw_ff[`PSW_N] == $past(diff[7]) &&
         mem[$past(ea)] == $past(mem_rd_ff | acc_ff))
      else $error("test-and-set result wrong");
   a_branch_target: assert property (
      commit && taken |=> pc_ff == $past(target))
      else $error("branch target wrong");
   a_cond_not_taken: assert property (
      state_ff == ST_READ && cls == OC_COND_BR && !cond_br |=>
         exec_busy ##1 !exec_busy)
      else $error("untaken branch not two cycles");
endmodule

// File: test_bit_ops_and_branch_exec.sv
// Self-checking bench for the bit-operation and branch execution unit
module test_bit_ops_and_branch_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic exec_busy;
   int fail_count = 0;
   int checks = 0;
   int seed = 32'h5a41;
   int n;
   logic [31:0] rd;
   logic [7:0] e_psw;
   logic [7:0] e_acc;
   logic [7:0] e_mem;
   logic [15:0] e_pc;
   logic [3:0] e_cyc;
   logic [7:0] o1;
   logic [7:0] o2;
   logic [8:0] op;

   always #2 sys_clk = ~sys_clk;

   bit_ops_and_branch_exec #(.ADDR_W(12)) dut_u (
      .sys_clk(sys_clk),
      .reset(reset),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .exec_busy(exec_busy)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until the rising edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      avs_write <= wr;
      avs_read <= ~wr;
      avs_address <= a;
      avs_writedata <= d;
      k = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && k < 200) begin
         k++;
         @(posedge sys_clk);
      end
      if (k == 200) fail_count++;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic model(input logic [7:0] c, input logic [7:0] a,
                        input logic [7:0] b2);
      logic [2:0] b;
      logic mb;
      logic tk;
      logic [7:0] df;
      logic [7:0] off;
      logic [15:0] len;
      b = b2[7:5];
      mb = e_mem[b] ^ b2[4];
      df = e_acc - e_mem;
      tk = 1'b0;
      off = a;
      len = 16'h0002;
      e_cyc = 4'h2;
      case (c)
         8'h8b: {e_psw[0], e_cyc, len} = {e_psw[0] & mb, 4'h4, 16'h0003};
         8'h6b: {e_psw[0], e_cyc, len} = {e_psw[0] | mb, 4'h5, 16'h0003};
         8'hab: {e_psw[0], e_cyc, len} = {e_psw[0] ^ mb, 4'h5, 16'h0003};
         8'hcb: {e_psw[0], e_cyc, len} = {mb, 4'h4, 16'h0003};
         8'h4b: {e_mem[b], e_cyc, len} = {~e_mem[b], 4'h5, 16'h0003};
         8'heb: {e_mem[b], e_cyc, len} = {e_psw[0], 4'h6, 16'h0003};
         8'h0c, 8'h1c: begin
            e_psw[1] = (e_acc & e_mem) == 8'h00;
            {e_psw[7], e_psw[6]} = e_mem[7:6];
            e_cyc = c[4] ? 4'h5 : 4'h4;
            len = c[4] ? 16'h0003 : 16'h0002;
         end
         8'h3c, 8'h5c: begin
            {e_psw[7], e_psw[1]} = {df[7], df == 8'h00};
            e_mem = c[6] ? (e_mem & ~e_acc) : (e_mem | e_acc);
            {e_cyc, len} = {4'h6, 16'h0003};
         end
         8'h0b, 8'h2b: e_acc[a[2:0]] = ~c[5];
         8'h20, 8'ha0: {e_psw[0], len} = {c[7], 16'h0001};
         8'h40, 8'hc0: {e_psw[5], len} = {c[7], 16'h0001};
         8'h80: {e_psw[6], len} = {1'b0, 16'h0001};
         8'h50, 8'hd0: tk = e_psw[0] == c[7];
         8'hf0, 8'h70: tk = e_psw[1] == c[7];
         8'h90, 8'h10: tk = e_psw[7] == c[7];
         default: begin
            case (c[1:0])
               2'h1: {e_mem[c[7:5]], e_cyc} = {~c[4], 4'h4};
               2'h2: {tk, e_cyc} = {e_acc[c[7:5]] == ~c[4], 4'h4};
               default: begin
                  {tk, e_cyc, off} = {e_mem[c[7:5]] == ~c[4], 4'h5, b2};
                  len = 16'h0003;
               end
            endcase
         end
      endcase
      // Offset counted from the address after the branch
      e_pc = e_pc + len + (tk ? {{8{off[7]}}, off} : 16'h0000);
      e_cyc = e_cyc + (tk ? 4'h2 : 4'h0);
   endtask

   task automatic run(input logic [7:0] c, input logic [11:0] ma);
      e_psw = 8'($random(seed));
      e_acc = 8'($random(seed));
      e_mem = 8'($random(seed));
      e_pc = 16'($random(seed));
      bus(1'b1, 5'h04, {24'h00_0000, e_psw});
      bus(1'b1, 5'h08, {24'h00_0000, e_acc});
      bus(1'b1, 5'h0c, {16'h0000, e_pc});
      bus(1'b1, 5'h10, {20'h0_0000, ma});
      bus(1'b1, 5'h14, {24'h00_0000, e_mem});
      model(c, o1, o2);
      bus(1'b1, 5'h00, {8'h00, o2, o1, c});
      n = 0;
      @(negedge sys_clk);
      while (exec_busy === 1'b1 && n < 20) begin
         n++;
         @(negedge sys_clk);
      end
      chk(32'(n), {28'h000_0000, e_cyc});
      bus(1'b0, 5'h04, 32'h0000_0000);
      chk(rd, {24'h00_0000, e_psw});
      bus(1'b0, 5'h08, 32'h0000_0000);
      chk(rd, {24'h00_0000, e_acc});
      bus(1'b0, 5'h0c, 32'h0000_0000);
      chk(rd, {16'h0000, e_pc});
      bus(1'b0, 5'h14, 32'h0000_0000);
      chk(rd, {24'h00_0000, e_mem});
      bus(1'b0, 5'h18, 32'h0000_0000);
      chk({28'h000_0000, rd[7:4]}, {28'h000_0000, e_cyc});
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Roughly 8k cycles expected; generous margin before declaring a hang
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      bus(1'b0, 5'h04, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b0, 5'h08, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b0, 5'h0c, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b0, 5'h1c, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test reset and unmapped read done");
      for (op = 9'h000; op < 9'h100; op++) begin
         if (op[3:0] inside {4'h1, 4'h2, 4'h3} || op[7:0] inside {8'h8b,
             8'h6b, 8'hab, 8'hcb, 8'h4b, 8'heb, 8'h0c, 8'h1c, 8'h3c,
             8'h5c, 8'h0b, 8'h2b, 8'h20, 8'ha0, 8'h40, 8'hc0, 8'h80,
             8'h50, 8'hd0, 8'hf0, 8'h70, 8'h90, 8'h10}) begin
            repeat (3) begin
               o1 = 8'($random(seed));
               o2 = 8'($random(seed));
               // Direct-page forms carry a page-zero address in one byte
               if (op[3:0] inside {4'h1, 4'h3} || op[7:0] == 8'h0c) begin
                  run(op[7:0], {4'h0, o1});
               end else begin
                  run(op[7:0], {o2[3:0], o1});
               end
            end
            $display("test opcode %h done", op[7:0]);
         end
      end
      // Undecoded opcode raises the sticky flag; writing one clears it
      bus(1'b1, 5'h00, 32'h0000_00ff);
      bus(1'b0, 5'h18, 32'h0000_0000);
      chk({30'h0000_0000, rd[1:0]}, 32'h0000_0002);
      bus(1'b1, 5'h18, 32'h0000_0002);
      bus(1'b0, 5'h18, 32'h0000_0000);
      chk({30'h0000_0000, rd[1:0]}, 32'h0000_0000);
      $display("test illegal opcode done");
      report_and_stop();
   end
endmodule
